//--- verilog/mprc_pkg.sv
// package of constants for the maintenance panel run control
// Summary of operation
// - register set/clear buttons act in maintenance mode only when stopped and channels idle.
// - in maintenance mode Go is taken only with channels idle and no test cycle running.
// - entry with first accumulator: copy to instruction word, store, clear it, advance, stop.
// - entry with second accumulator: copy, store, advance counter, stop; accumulator kept.
// - test mode repeats clear 10us, wait 10us, Go 0.1us, run 120us, stop 10us.
// - extended test repeats both clears 5ms, wait 10us, Go 0.1us, run 30ms, stop 10us.
// - with step mode the opening clear of a test cycle becomes an equal plain wait.
// - dropping extended selection during test mode returns to normal cycle timing.
// - sweep with step: each Go shows the word at the counter, no execution, then stops.
// - sweep mode disables the manual entry sequence so storage is not overwritten.
// - sweep without step: Go sweeps storage continuously without executing anything.
// - advance inhibit holds the program counter; taken jumps still move it.
// - step mode after an internal clear: first Go fetches and stops before executing.
// - step mode: Go resolves indirect address and stops; next Go executes then stops.
// - step without prior clear: indirect resolves and stops, else executes and stops.
// - three selective jump switches feed jump opcode 75, changeable at any time.
// - three selective stop switches halt on stop opcode 76 in maintenance mode.
// - auto-load starts loading whether running or stopped, without maintenance mode.
// - manual interrupt enters a routine only when its mask bit and system are active.
// - external clear resets channels and equipment; internal clear resets computation logic.
// - Go runs the held instruction, or fetches from the counter after an internal clear.
// - Stop halts when the current instruction completes, then registers are shown.
package mprc_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int NS_PER_S = 1_000_000_000;
	localparam int CLK_NS = NS_PER_S / CLK_HZ;
	// phase lengths in their printed units
	localparam int T_CLR_NORM_NS = 10_000;
	localparam int T_WAIT_NS = 10_000;
	localparam int T_GO_NS = 100;
	localparam int T_RUN_NORM_NS = 120_000;
	localparam int T_STOP_NS = 10_000;
	localparam int T_CLR_EXT_MS = 5;
	localparam int T_RUN_EXT_MS = 30;
	localparam int NS_PER_MS = 1_000_000;
	// cycle counts derived from them; ns times rounded up, ms times divided without rounding
	localparam int C_CLR_NORM = (T_CLR_NORM_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_WAIT = (T_WAIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_GO = (T_GO_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_RUN_NORM = (T_RUN_NORM_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_STOP = (T_STOP_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_CLR_EXT = (T_CLR_EXT_MS * NS_PER_MS) / CLK_NS;
	localparam int C_RUN_EXT = (T_RUN_EXT_MS * NS_PER_MS) / CLK_NS;
	localparam int CNT_W = 20;
	localparam logic [5:0] OP_SEL_JUMP = 6'h3D;
	localparam logic [5:0] OP_SEL_STOP = 6'h3E;
	localparam logic [14:0] P_RESET = 15'h0000;
	localparam logic [47:0] WORD_RESET = 48'h0000_0000_0000;
	typedef enum logic [4:0] {
		TS_IDLE = 5'b00001,
		TS_CLEAR = 5'b00010,
		TS_WAIT = 5'b00100,
		TS_GO = 5'b01000,
		TS_RUN = 5'b10000
	} mprc_test_type;
	typedef enum logic [5:0] {
		RS_STOP = 6'b000001,
		RS_RUN = 6'b000010,
		RS_ENTRY = 6'b000100,
		RS_SWEEP = 6'b001000,
		RS_FETCH = 6'b010000,
		RS_STEP = 6'b100000
	} mprc_run_type;
endpackage

//--- verilog/mprc_top.sv
// run and step control of the maintenance panel
`timescale 1ns/1ns
module mprc_top #(
	parameter int CLR_EXT_CYC = mprc_pkg::C_CLR_EXT,
	parameter int RUN_EXT_CYC = mprc_pkg::C_RUN_EXT
) (
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	// locking switches
	input wire logic MAINT_MODE_IN,
	input wire logic ENTRY_MODE_IN,
	input wire logic SEL_SECOND_ACC_IN,
	input wire logic TEST_MODE_IN,
	input wire logic EXT_TEST_IN,
	input wire logic SWEEP_MODE_IN,
	input wire logic INHIBIT_ADVANCE_IN,
	input wire logic STEP_MODE_IN,
	input wire logic [2:0] SEL_JUMP_IN,
	input wire logic [2:0] SEL_STOP_IN,
	input wire logic AUTO_LOAD_IN,
	// momentary buttons
	input wire logic GO_IN,
	input wire logic STOP_IN,
	input wire logic EXT_CLEAR_IN,
	input wire logic INT_CLEAR_IN,
	input wire logic MAN_INT_IN,
	input wire logic REG_SET_IN,
	input wire logic REG_CLEAR_IN,
	// processor status
	input wire logic CHANNEL_ACTIVE_IN,
	input wire logic INT_MASK_MANUAL_IN,
	input wire logic INT_SYSTEM_ACTIVE_IN,
	input wire logic INSTR_DONE_IN,
	input wire logic INDIRECT_IN,
	input wire logic PAIR_HALF_DONE_IN,
	input wire logic [5:0] OPCODE_IN,
	input wire logic JUMP_TAKEN_IN,
	input wire logic [14:0] JUMP_ADDR_IN,
	input wire logic [47:0] ACC_FIRST_IN,
	input wire logic [47:0] ACC_SECOND_IN,
	input wire logic [47:0] MEM_RDATA_IN,
	// outputs
	output logic RUNNING_OUT,
	output logic [14:0] PROG_COUNTER_OUT,
	output logic [47:0] INSTR_WORD_OUT,
	output logic MEM_WRITE_OUT,
	output logic MEM_READ_OUT,
	output logic [47:0] MEM_WDATA_OUT,
	output logic CLEAR_FIRST_ACC_OUT,
	output logic REG_EDIT_EN_OUT,
	output logic INT_MASTER_CLEAR_OUT,
	output logic EXT_MASTER_CLEAR_OUT,
	output logic EXECUTE_OUT,
	output logic RESOLVE_INDIRECT_OUT,
	output logic [2:0] SEL_JUMP_OUT,
	output logic SEL_STOP_HALT_OUT,
	output logic AUTO_LOAD_START_OUT,
	output logic MAN_INT_OUT,
	output logic DISPLAY_OUT
);
	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	localparam int NSW = 22;
	logic [NSW-1:0] raw_in;
	logic [NSW-1:0] meta_q;
	logic [NSW-1:0] sync_q;
	logic [NSW-1:0] prev_q;
	assign raw_in = {MAN_INT_IN, REG_CLEAR_IN, REG_SET_IN, INT_CLEAR_IN, EXT_CLEAR_IN, STOP_IN,
		GO_IN, AUTO_LOAD_IN, SEL_STOP_IN, SEL_JUMP_IN, STEP_MODE_IN, INHIBIT_ADVANCE_IN,
		SWEEP_MODE_IN, EXT_TEST_IN, TEST_MODE_IN, SEL_SECOND_ACC_IN, ENTRY_MODE_IN,
		MAINT_MODE_IN};
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= raw_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	logic maint, entry, second_acc, test_sw, ext_sw, sweep, inhibit, step;
	logic [2:0] sel_jump, sel_stop;
	assign maint = sync_q[0];
	assign entry = sync_q[1];
	assign second_acc = sync_q[2];
	assign test_sw = sync_q[3];
	assign ext_sw = sync_q[4];
	assign sweep = sync_q[5];
	assign inhibit = sync_q[6];
	assign step = sync_q[7];
	assign sel_jump = sync_q[10:8];
	assign sel_stop = sync_q[13:11];
	// one pulse per press on rising edge of the synchronised level
	logic [NSW-1:0] rise;
	assign rise = sync_q & ~prev_q;
	logic auto_p, go_p, stop_p, ext_clr_p, int_clr_p, set_p, clr_p, int_p, test_rise;
	assign test_rise = rise[3];
	assign auto_p = rise[14];
	assign go_p = rise[15];
	assign stop_p = rise[16];
	assign ext_clr_p = rise[17];
	assign int_clr_p = rise[18];
	assign set_p = rise[19];
	assign clr_p = rise[20];
	assign int_p = rise[21];

	// ----------------------------------------------------------------
	// test cycle sequencer
	// ----------------------------------------------------------------
	mprc_pkg::mprc_test_type ts_q;
	logic [mprc_pkg::CNT_W-1:0] tcnt_q;
	logic ext_cycle_q;
	logic test_go, test_clear, test_ext_clear, test_running;
	logic [mprc_pkg::CNT_W-1:0] phase_len;
	assign test_running = (ts_q != mprc_pkg::TS_IDLE);
	always_comb begin
		unique case (ts_q)
			mprc_pkg::TS_CLEAR: phase_len = ext_cycle_q ? mprc_pkg::CNT_W'(CLR_EXT_CYC)
				: mprc_pkg::CNT_W'(mprc_pkg::C_CLR_NORM);
			mprc_pkg::TS_WAIT: phase_len = mprc_pkg::CNT_W'(mprc_pkg::C_WAIT);
			mprc_pkg::TS_GO: phase_len = mprc_pkg::CNT_W'(mprc_pkg::C_GO);
			mprc_pkg::TS_RUN: phase_len = ext_cycle_q ? mprc_pkg::CNT_W'(RUN_EXT_CYC)
				: mprc_pkg::CNT_W'(mprc_pkg::C_RUN_NORM);
			default: phase_len = mprc_pkg::CNT_W'(mprc_pkg::C_STOP);
		endcase
	end
	// extended timing latched when test mode is switched on, dropped when its switch drops
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ext_cycle_q <= 1'b0;
		end else if (test_rise) begin
			ext_cycle_q <= ext_sw;
		end else if (!ext_sw) begin
			ext_cycle_q <= 1'b0;
		end
	end
	logic stop_phase_q;
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ts_q <= mprc_pkg::TS_IDLE;
			tcnt_q <= '0;
			stop_phase_q <= 1'b0;
		end else if (!test_sw) begin
			ts_q <= mprc_pkg::TS_IDLE;
			tcnt_q <= '0;
			stop_phase_q <= 1'b0;
		end else if (ts_q == mprc_pkg::TS_IDLE) begin
			ts_q <= mprc_pkg::TS_CLEAR;
			tcnt_q <= '0;
		end else if (tcnt_q + 1'b1 >= phase_len) begin
			tcnt_q <= '0;
			unique case (ts_q)
				mprc_pkg::TS_CLEAR: ts_q <= mprc_pkg::TS_WAIT;
				mprc_pkg::TS_WAIT: begin
					if (stop_phase_q) begin
						stop_phase_q <= 1'b0;
						ts_q <= mprc_pkg::TS_CLEAR;
					end else begin
						ts_q <= mprc_pkg::TS_GO;
					end
				end
				mprc_pkg::TS_GO: ts_q <= mprc_pkg::TS_RUN;
				default: begin
					// stop phase reuses the wait state with the wait length
					ts_q <= mprc_pkg::TS_WAIT;
					stop_phase_q <= 1'b1;
				end
			endcase
		end else begin
			tcnt_q <= tcnt_q + 1'b1;
		end
	end
	// the stop phase is the wait state flagged; its length is the same 10us
	assign test_clear = (ts_q == mprc_pkg::TS_CLEAR) && !step;
	assign test_ext_clear = test_clear && ext_cycle_q;
	assign test_go = (ts_q == mprc_pkg::TS_GO) && (tcnt_q == '0);

	// ----------------------------------------------------------------
	// go / stop gating and clears
	// ----------------------------------------------------------------
	mprc_pkg::mprc_run_type rs_q;
	logic stopped, go_ok, int_clr_any, after_clear_q;
	assign stopped = (rs_q == mprc_pkg::RS_STOP);
	assign go_ok = go_p && !CHANNEL_ACTIVE_IN && !test_running && maint;
	assign int_clr_any = int_clr_p || test_clear;
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			INT_MASTER_CLEAR_OUT <= 1'b0;
			EXT_MASTER_CLEAR_OUT <= 1'b0;
		end else begin
			INT_MASTER_CLEAR_OUT <= int_clr_any;
			EXT_MASTER_CLEAR_OUT <= ext_clr_p || test_ext_clear;
		end
	end
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			after_clear_q <= 1'b0;
		end else if (int_clr_any) begin
			after_clear_q <= 1'b1;
		end else if (rs_q == mprc_pkg::RS_FETCH && !MEM_READ_OUT) begin
			after_clear_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	logic halt_stop_op, indirect_pending_q;
	// the opcode carries no switch designator, so any set stop switch arms the halt
	assign halt_stop_op = INSTR_DONE_IN && maint && (OPCODE_IN == mprc_pkg::OP_SEL_STOP)
		&& (sel_stop != 3'h0);
	// a stop press is held until the running instruction ends; the one-cycle pulse
	// would otherwise be lost between two completions
	logic stop_req_q;
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			stop_req_q <= 1'b0;
		end else if (stop_p && !stopped) begin
			stop_req_q <= 1'b1;
		end else if (stopped) begin
			stop_req_q <= 1'b0;
		end
	end
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			rs_q <= mprc_pkg::RS_STOP;
			PROG_COUNTER_OUT <= mprc_pkg::P_RESET;
			INSTR_WORD_OUT <= mprc_pkg::WORD_RESET;
			MEM_WRITE_OUT <= 1'b0;
			MEM_READ_OUT <= 1'b0;
			MEM_WDATA_OUT <= mprc_pkg::WORD_RESET;
			CLEAR_FIRST_ACC_OUT <= 1'b0;
			EXECUTE_OUT <= 1'b0;
			RESOLVE_INDIRECT_OUT <= 1'b0;
			indirect_pending_q <= 1'b0;
		end else begin
			MEM_WRITE_OUT <= 1'b0;
			MEM_READ_OUT <= 1'b0;
			CLEAR_FIRST_ACC_OUT <= 1'b0;
			RESOLVE_INDIRECT_OUT <= 1'b0;
			if (int_clr_any) begin
				rs_q <= mprc_pkg::RS_STOP;
				EXECUTE_OUT <= 1'b0;
				indirect_pending_q <= 1'b0;
				PROG_COUNTER_OUT <= mprc_pkg::P_RESET;
				INSTR_WORD_OUT <= mprc_pkg::WORD_RESET;
			end else begin
				// the counter steps only after the write, so the store lands at the old address
				if (MEM_WRITE_OUT) begin
					PROG_COUNTER_OUT <= PROG_COUNTER_OUT + 15'h0001;
				end
				unique case (rs_q)
					mprc_pkg::RS_STOP: begin
						if (go_ok || test_go) begin
							if (entry && !sweep) begin
								rs_q <= mprc_pkg::RS_ENTRY;
							end else if (sweep) begin
								rs_q <= mprc_pkg::RS_SWEEP;
							end else if (after_clear_q) begin
								rs_q <= mprc_pkg::RS_FETCH;
							end else if (step && INDIRECT_IN && !indirect_pending_q) begin
								RESOLVE_INDIRECT_OUT <= 1'b1;
								indirect_pending_q <= 1'b1;
							end else begin
								indirect_pending_q <= 1'b0;
								EXECUTE_OUT <= 1'b1;
								rs_q <= step ? mprc_pkg::RS_STEP : mprc_pkg::RS_RUN;
							end
						end
					end
					mprc_pkg::RS_ENTRY: begin
						INSTR_WORD_OUT <= second_acc ? ACC_SECOND_IN : ACC_FIRST_IN;
						MEM_WDATA_OUT <= second_acc ? ACC_SECOND_IN : ACC_FIRST_IN;
						MEM_WRITE_OUT <= 1'b1;
						CLEAR_FIRST_ACC_OUT <= !second_acc;
						rs_q <= mprc_pkg::RS_STOP;
					end
					mprc_pkg::RS_SWEEP: begin
						// read issued one cycle, data latched the next
						if (!MEM_READ_OUT) begin
							MEM_READ_OUT <= 1'b1;
						end else begin
							INSTR_WORD_OUT <= MEM_RDATA_IN;
							PROG_COUNTER_OUT <= PROG_COUNTER_OUT + 15'h0001;
							if (step || stop_p || stop_req_q || !sweep) begin
								rs_q <= mprc_pkg::RS_STOP;
							end
						end
					end
					mprc_pkg::RS_FETCH: begin
						if (!MEM_READ_OUT) begin
							MEM_READ_OUT <= 1'b1;
						end else begin
							INSTR_WORD_OUT <= MEM_RDATA_IN;
							if (step) begin
								rs_q <= mprc_pkg::RS_STOP;
							end else begin
								EXECUTE_OUT <= 1'b1;
								rs_q <= mprc_pkg::RS_RUN;
							end
						end
					end
					default: begin
						// RS_RUN and RS_STEP: the processor executes
						if (INSTR_DONE_IN) begin
							if (JUMP_TAKEN_IN) begin
								PROG_COUNTER_OUT <= JUMP_ADDR_IN;
							end else if (!inhibit && !PAIR_HALF_DONE_IN) begin
								PROG_COUNTER_OUT <= PROG_COUNTER_OUT + 15'h0001;
							end
							if ((rs_q == mprc_pkg::RS_STEP) || stop_p || stop_req_q || halt_stop_op
								|| (ts_q == mprc_pkg::TS_WAIT && stop_phase_q)) begin
								EXECUTE_OUT <= 1'b0;
								rs_q <= mprc_pkg::RS_STOP;
							end
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// panel side effects and status
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			RUNNING_OUT <= 1'b0;
			REG_EDIT_EN_OUT <= 1'b0;
			SEL_JUMP_OUT <= 3'h0;
			SEL_STOP_HALT_OUT <= 1'b0;
			AUTO_LOAD_START_OUT <= 1'b0;
			MAN_INT_OUT <= 1'b0;
			DISPLAY_OUT <= 1'b0;
		end else begin
			RUNNING_OUT <= !stopped;
			REG_EDIT_EN_OUT <= maint && stopped && !CHANNEL_ACTIVE_IN
				&& (set_p || clr_p);
			SEL_JUMP_OUT <= sel_jump;
			SEL_STOP_HALT_OUT <= halt_stop_op;
			AUTO_LOAD_START_OUT <= auto_p;
			MAN_INT_OUT <= int_p && INT_MASK_MANUAL_IN && INT_SYSTEM_ACTIVE_IN;
			DISPLAY_OUT <= stopped;
		end
	end
endmodule // mprc_top

//--- dv/mprc_chk.sv
// port checker of the maintenance panel run control, bound to the top module
`timescale 1ns/1ns
module mprc_chk #(
	parameter int CLR_EXT_CYC = 20,
	parameter int RUN_EXT_CYC = 40
) (
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic SWEEP_MODE_IN,
	input wire logic CHANNEL_ACTIVE_IN,
	input wire logic INT_MASK_MANUAL_IN,
	input wire logic INT_SYSTEM_ACTIVE_IN,
	input wire logic AUTO_LOAD_IN,
	input wire logic INT_CLEAR_IN,
	input wire logic [47:0] MEM_RDATA_IN,
	input wire logic RUNNING_OUT,
	input wire logic [14:0] PROG_COUNTER_OUT,
	input wire logic [47:0] INSTR_WORD_OUT,
	input wire logic MEM_WRITE_OUT,
	input wire logic MEM_READ_OUT,
	input wire logic [47:0] MEM_WDATA_OUT,
	input wire logic CLEAR_FIRST_ACC_OUT,
	input wire logic REG_EDIT_EN_OUT,
	input wire logic INT_MASTER_CLEAR_OUT,
	input wire logic EXT_MASTER_CLEAR_OUT,
	input wire logic AUTO_LOAD_START_OUT,
	input wire logic MAN_INT_OUT
);
	// ----
	// run lengths
	// ----
	int icl_q;
	int ecl_q;
	int swp_q;
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			icl_q <= 0;
			ecl_q <= 0;
			swp_q <= 0;
		end else begin
			icl_q <= INT_MASTER_CLEAR_OUT ? icl_q + 1 : 0;
			ecl_q <= EXT_MASTER_CLEAR_OUT ? ecl_q + 1 : 0;
			swp_q <= SWEEP_MODE_IN ? swp_q + 1 : 0;
		end
	end
	// ----
	// properties
	// ----
	default clocking dc @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	sequence s_iclr;
		$rose(INT_CLEAR_IN) ##[2:5] INT_MASTER_CLEAR_OUT;
	endsequence
	property p_wr_data;
		MEM_WRITE_OUT |-> MEM_WDATA_OUT == INSTR_WORD_OUT;
	endproperty
	property p_clr_acc;
		CLEAR_FIRST_ACC_OUT |-> MEM_WRITE_OUT;
	endproperty
	// sweep needs a few edges to pass the synchroniser before it blocks entry
	property p_sweep_nowr;
		MEM_WRITE_OUT |-> swp_q < 5;
	endproperty
	property p_rd_word;
		$rose(MEM_READ_OUT) |=> (INSTR_WORD_OUT == $past(MEM_RDATA_IN));
	endproperty
	property p_edit;
		REG_EDIT_EN_OUT |-> !$past(CHANNEL_ACTIVE_IN) && !RUNNING_OUT;
	endproperty
	property p_man_int;
		MAN_INT_OUT |-> $past(INT_MASK_MANUAL_IN) && $past(INT_SYSTEM_ACTIVE_IN);
	endproperty
	property p_icl_len;
		$fell(INT_MASTER_CLEAR_OUT) |-> icl_q inside {1, mprc_pkg::C_CLR_NORM, CLR_EXT_CYC};
	endproperty
	property p_ecl_len;
		$fell(EXT_MASTER_CLEAR_OUT) |-> ecl_q inside {1, CLR_EXT_CYC};
	endproperty
	property p_auto;
		$rose(AUTO_LOAD_IN) |-> ##[2:5] AUTO_LOAD_START_OUT;
	endproperty
	property p_iclr;
		s_iclr |-> ##[0:1] (PROG_COUNTER_OUT == 15'h0000);
	endproperty
	a_wr_data: assert property (p_wr_data) else $error("stored word differs from instruction word");
	a_clr_acc: assert property (p_clr_acc) else $error("accumulator cleared without a store");
	a_sweep_nowr: assert property (p_sweep_nowr) else $error("store while sweeping");
	a_rd_word: assert property (p_rd_word) else $error("read word not shown");
	a_edit: assert property (p_edit) else $error("register edit while busy");
	a_man_int: assert property (p_man_int) else $error("manual interrupt not gated");
	a_icl_len: assert property (p_icl_len) else $error("internal clear length wrong");
	a_ecl_len: assert property (p_ecl_len) else $error("external clear length wrong");
	a_auto: assert property (p_auto) else $error("auto load not started");
	a_iclr: assert property (p_iclr) else $error("counter not cleared");
endmodule // mprc_chk
bind mprc_top mprc_chk #(.CLR_EXT_CYC(CLR_EXT_CYC), .RUN_EXT_CYC(RUN_EXT_CYC)) chk_u (
	.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .SWEEP_MODE_IN(SWEEP_MODE_IN),
	.CHANNEL_ACTIVE_IN(CHANNEL_ACTIVE_IN), .INT_MASK_MANUAL_IN(INT_MASK_MANUAL_IN),
	.INT_SYSTEM_ACTIVE_IN(INT_SYSTEM_ACTIVE_IN), .AUTO_LOAD_IN(AUTO_LOAD_IN),
	.INT_CLEAR_IN(INT_CLEAR_IN), .MEM_RDATA_IN(MEM_RDATA_IN), .RUNNING_OUT(RUNNING_OUT),
	.PROG_COUNTER_OUT(PROG_COUNTER_OUT), .INSTR_WORD_OUT(INSTR_WORD_OUT),
	.MEM_WRITE_OUT(MEM_WRITE_OUT), .MEM_READ_OUT(MEM_READ_OUT), .MEM_WDATA_OUT(MEM_WDATA_OUT),
	.CLEAR_FIRST_ACC_OUT(CLEAR_FIRST_ACC_OUT), .REG_EDIT_EN_OUT(REG_EDIT_EN_OUT),
	.INT_MASTER_CLEAR_OUT(INT_MASTER_CLEAR_OUT), .EXT_MASTER_CLEAR_OUT(EXT_MASTER_CLEAR_OUT),
	.AUTO_LOAD_START_OUT(AUTO_LOAD_START_OUT), .MAN_INT_OUT(MAN_INT_OUT)
);

//--- dv/mprc_proc_model.sv
// storage and instruction pacing model of the processor beside the panel logic
`timescale 1ns/1ns
module mprc_proc_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic exe_in,
	input wire logic [14:0] addr_in,
	input wire logic [47:0] wdata_in,
	output logic [47:0] rdata_out,
	output logic done_out
);
	logic [47:0] mem_q [16];
	logic [1:0] pace_q;
	// storage answers within the read cycle; the panel takes the word at the edge ending it
	assign rdata_out = rd_in ? mem_q[addr_in[3:0]] : 48'h0;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < 16; i++) begin
				mem_q[i] <= 48'h0;
			end
		end else if (wr_in) begin
			mem_q[addr_in[3:0]] <= wdata_in;
		end
	end
	// every instruction takes four cycles
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pace_q <= 2'h0;
			done_out <= 1'b0;
		end else begin
			pace_q <= exe_in ? pace_q + 2'h1 : 2'h0;
			done_out <= exe_in && (pace_q == 2'h3);
		end
	end
endmodule // mprc_proc_model

//--- dv/tb.sv
// self-checking bench of the maintenance panel run control
`timescale 1ns/1ns
module tb;
	localparam int CE = 20;
	localparam int RE = 40;
	logic clk = 0, rst_n = 0, maint = 0, entry = 0, sec = 0, test = 0, ext = 0, sweep = 0;
	logic inh = 0, step = 0, aload = 0, chan = 0, mask = 0, isys = 0, ind = 0, jmp = 0, done;
	logic [6:0] btn = '0;
	logic [5:0] op = '0;
	logic [2:0] sj = '0, ss = '0, sjo;
	logic [47:0] acc1 = 48'h1234_5678_9ABC, acc2 = 48'hFEDC_BA98_7654, iw, wd, rdat, last_wd;
	logic [14:0] pc;
	logic run, wr, rd, cfa, edit, icl, ecl, exe, mint, al, sst, disp, ri;
	logic [47:0] n_wr = '0, n_cfa = '0, n_ed = '0, n_rd = '0, n_exe = '0, n_mi = '0, n_al = '0;
	logic [47:0] n_sst = '0, n_icl = '0, cl = '0, el = '0, icl_len = '0, ecl_len = '0, n_ri = '0;
	int n_mismatch = 0, checks = 0;
	always #50 clk = ~clk;
	mprc_top #(.CLR_EXT_CYC(CE), .RUN_EXT_CYC(RE)) dut_u (
		.CLK_IN(clk), .RESET_N_IN(rst_n), .MAINT_MODE_IN(maint), .ENTRY_MODE_IN(entry),
		.SEL_SECOND_ACC_IN(sec), .TEST_MODE_IN(test), .EXT_TEST_IN(ext), .SWEEP_MODE_IN(sweep),
		.INHIBIT_ADVANCE_IN(inh), .STEP_MODE_IN(step), .SEL_JUMP_IN(sj), .SEL_STOP_IN(ss),
		.AUTO_LOAD_IN(aload), .GO_IN(btn[0]), .STOP_IN(btn[1]), .EXT_CLEAR_IN(btn[3]),
		.INT_CLEAR_IN(btn[2]), .MAN_INT_IN(btn[4]), .REG_SET_IN(btn[5]), .REG_CLEAR_IN(btn[6]),
		.CHANNEL_ACTIVE_IN(chan), .INT_MASK_MANUAL_IN(mask), .INT_SYSTEM_ACTIVE_IN(isys),
		.INSTR_DONE_IN(done), .INDIRECT_IN(ind), .PAIR_HALF_DONE_IN(1'b0), .OPCODE_IN(op),
		.JUMP_TAKEN_IN(jmp), .JUMP_ADDR_IN(15'h0005), .ACC_FIRST_IN(acc1), .ACC_SECOND_IN(acc2),
		.MEM_RDATA_IN(rdat), .RUNNING_OUT(run), .PROG_COUNTER_OUT(pc), .INSTR_WORD_OUT(iw),
		.MEM_WRITE_OUT(wr), .MEM_READ_OUT(rd), .MEM_WDATA_OUT(wd), .CLEAR_FIRST_ACC_OUT(cfa),
		.REG_EDIT_EN_OUT(edit), .INT_MASTER_CLEAR_OUT(icl), .EXT_MASTER_CLEAR_OUT(ecl),
		.EXECUTE_OUT(exe), .RESOLVE_INDIRECT_OUT(ri), .SEL_JUMP_OUT(sjo), .SEL_STOP_HALT_OUT(sst),
		.AUTO_LOAD_START_OUT(al), .MAN_INT_OUT(mint), .DISPLAY_OUT(disp));
	mprc_proc_model proc_u (.clk_in(clk), .rst_n_in(rst_n), .rd_in(rd), .wr_in(wr), .exe_in(exe),
		.addr_in(pc), .wdata_in(wd), .rdata_out(rdat), .done_out(done));
	// ----
	// monitors: pulses counted, clear run lengths latched at their end
	// ----
	always @(posedge clk) begin
		if (wr === 1'b1) last_wd = wd;
		n_wr += 48'(wr === 1'b1);
		n_cfa += 48'(cfa === 1'b1);
		n_ed += 48'(edit === 1'b1);
		n_rd += 48'(rd === 1'b1);
		n_exe += 48'(exe === 1'b1);
		n_mi += 48'(mint === 1'b1);
		n_al += 48'(al === 1'b1);
		n_sst += 48'(sst === 1'b1);
		n_ri += 48'(ri === 1'b1);
		n_icl += 48'(icl !== 1'b1 && cl != 0);
		if (icl !== 1'b1 && cl != 0) icl_len = cl;
		if (ecl !== 1'b1 && el != 0) ecl_len = el;
		cl = (icl === 1'b1) ? cl + 48'h1 : 48'h0;
		el = (ecl === 1'b1) ? el + 48'h1 : 48'h0;
	end
	// ----
	// shared tasks
	// ----
	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// held four cycles so the synchroniser and edge detect surely see it
	task automatic press(input int b);
		btn[b] = 1'b1;
		repeat (4) @(negedge clk);
		btn[b] = 1'b0;
		repeat (12) @(negedge clk);
	endtask
	task automatic next_clr();
		logic [47:0] n0 = n_icl;
		for (int i = 0; i < 4000 && n_icl == n0; i++) @(negedge clk);
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_entry();
		maint = 1'b1;
		entry = 1'b1;
		press(2);
		chan = 1'b1;
		press(0);
		press(5);
		chk("go_refused", n_wr, 48'h0);
		chk("edit_refused", n_ed, 48'h0);
		chan = 1'b0;
		press(5);
		chk("edit", n_ed, 48'h1);
		press(0);
		chk("wdata_first", last_wd, acc1);
		chk("acc_clear", n_cfa, 48'h1);
		sec = 1'b1;
		press(0);
		chk("wdata_second", last_wd, acc2);
		chk("acc_kept", n_cfa, 48'h1);
		chk("pc_adv", 48'(pc), 48'h2);
		chk("stopped", 48'(run), 48'h0);
	endtask
	task automatic t_sweep();
		logic [47:0] r0;
		sweep = 1'b1;
		step = 1'b1;
		press(2);
		chk("pc_clear", 48'(pc), 48'h0);
		press(0);
		chk("sweep_w0", iw, acc1);
		press(0);
		chk("sweep_w1", iw, acc2);
		chk("sweep_pc", 48'(pc), 48'h2);
		chk("no_store", n_wr, 48'h2);
		step = 1'b0;
		r0 = n_rd;
		press(0);
		chk("sweep_cont", 48'(n_rd > r0 + 48'h4), 48'h1);
		chk("sweep_noexe", n_exe, 48'h0);
		press(1);
		sweep = 1'b0;
		entry = 1'b0;
	endtask
	task automatic t_run();
		step = 1'b1;
		press(2);
		press(0);
		chk("step_fetch", iw, acc1);
		chk("step_noexe", n_exe, 48'h0);
		ind = 1'b1;
		press(0);
		chk("ind_resolve", n_ri, 48'h1);
		chk("ind_noexe", n_exe, 48'h0);
		ind = 1'b0;
		press(0);
		chk("step_exe", 48'(n_exe != 48'h0), 48'h1);
		chk("step_stop", 48'(run), 48'h0);
		step = 1'b0;
		press(0);
		chk("running", 48'(run), 48'h1);
		press(1);
		chk("halted", 48'(run), 48'h0);
		chk("display", 48'(disp), 48'h1);
		inh = 1'b1;
		press(2);
		press(0);
		repeat (30) @(negedge clk);
		chk("pc_held", 48'(pc), 48'h0);
		jmp = 1'b1;
		repeat (8) @(negedge clk);
		jmp = 1'b0;
		repeat (8) @(negedge clk);
		chk("pc_jump", 48'(pc), 48'h5);
		press(1);
		inh = 1'b0;
		op = 6'h3E;
		ss = 3'b001;
		press(0);
		chk("sel_stop", 48'(run), 48'h0);
		chk("sel_stop_n", 48'(n_sst != 48'h0), 48'h1);
		op = 6'h00;
		ss = 3'b000;
	endtask
	task automatic t_misc();
		sj = 3'b101;
		repeat (6) @(negedge clk);
		chk("sel_jump", 48'(sjo), 48'h5);
		isys = 1'b1;
		press(4);
		chk("int_masked", n_mi, 48'h0);
		mask = 1'b1;
		press(4);
		chk("int_taken", n_mi, 48'h1);
		maint = 1'b0;
		aload = 1'b1;
		repeat (8) @(negedge clk);
		chk("auto_load", n_al, 48'h1);
		aload = 1'b0;
		press(3);
		chk("ext_clear", ecl_len, 48'h1);
		maint = 1'b1;
	endtask
	task automatic t_test();
		logic [47:0] n0;
		test = 1'b1;
		next_clr();
		next_clr();
		chk("clr_norm", icl_len, 48'(mprc_pkg::C_CLR_NORM));
		test = 1'b0;
		ext = 1'b1;
		repeat (20) @(negedge clk);
		test = 1'b1;
		next_clr();
		chk("clr_ext_int", icl_len, 48'(CE));
		chk("clr_ext_ext", ecl_len, 48'(CE));
		ext = 1'b0;
		next_clr();
		next_clr();
		chk("clr_back", icl_len, 48'(mprc_pkg::C_CLR_NORM));
		test = 1'b0;
		step = 1'b1;
		repeat (20) @(negedge clk);
		test = 1'b1;
		n0 = n_icl;
		repeat (1700) @(negedge clk);
		chk("step_noclr", n_icl, n0);
		chk("step_noclr_lvl", cl, 48'h0);
		test = 1'b0;
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_entry();
		t_sweep();
		t_run();
		t_misc();
		t_test();
		close_out();
	end
	initial begin
		#2_500_000;
		n_mismatch++;
		close_out();
	end
endmodule // tb
